// ==== rtl/tpsv_top.sv ====
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ns
module tpsv_top
  import tpsv_pkg::*;
(
  input  wire logic          mclk,
  input  wire logic          arst_n,
  input  wire tpsv_avs_req_t avs_req,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  input  wire tpsv_tone_t    tone,
  input  wire logic          callprog_square_in,
  output logic               early_steer,
  input  wire logic          steer_level_in,
  output logic               guard_time_drive,
  output logic               guard_time_oe,
  output logic               irq_callprog_o,
  output logic               irq_callprog_oe,
  output logic               irq
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    tpsv_state_t state;
    logic [2:0]  cnt;
    logic [3:0]  cap_code;
    logic [3:0]  rx_code;
    logic        rx_valid;
    logic        dsteer;
    logic        early;
    logic        guard;
    logic        guard_oe;
    logic        pin_o;
    logic        pin_oe;
    logic [1:0]  ctrl;
    logic [1:0]  evt;
    logic [1:0]  mask;
    logic        ack;
    logic [31:0] rdata;
  } tpsv_top_st_t;

  tpsv_top_st_t top_reg;
  tpsv_top_st_t top_next;

  logic       steer_sync;
  logic [3:0] enc_code;
  logic       rd_fire;
  logic       wr_fire;
  logic [1:0] evt_set;
  logic [1:0] evt_clr;

  // ****************************************
  // helpers
  // ****************************************
  // two-stage synchroniser
  tpsv_sync u_steer_sync (
    .mclk   (mclk),
    .arst_n (arst_n),
    .d_in   (steer_level_in),
    .q_out  (steer_sync)
  );

  tpsv_code_enc u_code_enc (
    .mclk   (mclk),
    .arst_n (arst_n),
    .tone   (tone),
    .code_q (enc_code)
  );

  function automatic logic [31:0] tpsv_read_mux(input logic [4:0] addr,
                                                input tpsv_top_st_t s);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (addr)
      ADDR_RX_DATA: d[3:0] = s.rx_code;
      ADDR_STATUS: begin
        d[RX_DATA_VALID_POS] = s.rx_valid;
        d[DELAYED_STEER_POS] = ~s.dsteer;
      end
      ADDR_CTRL:  d[1:0] = s.ctrl;
      ADDR_EVENT: d[1:0] = s.evt;
      ADDR_MASK:  d[1:0] = s.mask;
      default:    d = 32'h0000_0000;
    endcase
    return d;
  endfunction : tpsv_read_mux

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    top_next     = top_reg;
    top_next.ack = 1'b0;
    evt_set      = 2'h0;
    evt_clr      = 2'h0;
    rd_fire      = top_reg.ack & avs_req.read;
    wr_fire      = top_reg.ack & avs_req.write;

    // bus: one wait cycle, read data captured with the request
    if ((avs_req.read | avs_req.write) & ~top_reg.ack) begin
      top_next.ack   = 1'b1;
      top_next.rdata = tpsv_read_mux(avs_req.address, top_reg);
    end
    if (wr_fire) begin
      case (avs_req.address)
        ADDR_CTRL:  top_next.ctrl = avs_req.writedata[1:0];
        ADDR_MASK:  top_next.mask = avs_req.writedata[1:0];
        ADDR_EVENT: evt_clr       = avs_req.writedata[1:0];
        default:    top_next.ctrl = top_reg.ctrl;
      endcase
    end
    // and with it the receive interrupt
    if (rd_fire && avs_req.address == ADDR_STATUS) begin
      top_next.rx_valid = 1'b0;
    end

    // early steer tracks the signal condition
    // tone-pair detection off in call progress mode
    top_next.early = tone.valid & ~top_reg.ctrl[CTRL_CALLPROG_POS];

    // no registration unless the steer input crosses
    // short dropouts leave the steer input above threshold
    case (top_reg.state)
      TPSV_IDLE: begin
        if (steer_sync && top_reg.early) begin
          top_next.cap_code = enc_code;
          top_next.cnt      = 3'h0;
          top_next.state    = TPSV_SETTLE;
        end
      end
      TPSV_SETTLE: begin
        if (top_reg.cnt == SETTLE_LAST) begin
          top_next.state    = TPSV_VALID;
          top_next.dsteer   = 1'b1;
          // output latch loads on the active transition
          top_next.rx_code  = top_reg.cap_code;
          // a set here overrides the status read clear
          top_next.rx_valid = 1'b1;
          evt_set[EVT_NEW_DATA_POS] = 1'b1;
        end else begin
          top_next.cnt = top_reg.cnt + 3'h1;
        end
      end
      TPSV_VALID: begin
        // release only when the absent guard time has passed
        // receive code left untouched on tone end
        if (!steer_sync) begin
          top_next.state  = TPSV_IDLE;
          top_next.dsteer = 1'b0;
          evt_set[EVT_TONE_END_POS] = 1'b1;
        end
      end
      default: begin
        top_next.state  = TPSV_IDLE;
        top_next.dsteer = 1'b0;
      end
    endcase

    // sticky events, set wins over write-one-to-clear
    top_next.evt = (top_reg.evt & ~evt_clr) | evt_set;

    // guard drive from early steer and steer level
    // held high while early steer and the synchronised steer level both stay high
    top_next.guard    = top_reg.early & steer_sync;
    top_next.guard_oe = 1'b1;

    // shared pin: square wave in call progress mode, open drain irq otherwise
    if (top_reg.ctrl[CTRL_CALLPROG_POS]) begin
      // call progress output only in this mode
      top_next.pin_o  = callprog_square_in;
      top_next.pin_oe = 1'b1;
    end else begin
      // pull low while new delayed steer data is pending and the irq mode bit is set
      top_next.pin_o  = 1'b0;
      top_next.pin_oe = top_reg.ctrl[CTRL_IRQ_MODE_POS] & top_reg.rx_valid;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      top_reg          <= '0;
      top_reg.state    <= TPSV_IDLE;
      top_reg.cap_code <= CODE_RST;
      top_reg.rx_code  <= CODE_RST;
      top_reg.ctrl     <= CTRL_RST;
      top_reg.mask     <= MASK_RST;
    end else begin
      top_reg <= top_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign avs_readdata     = top_reg.rdata;
  assign avs_waitrequest  = (avs_req.read | avs_req.write) & ~top_reg.ack;
  assign early_steer      = top_reg.early;
  assign guard_time_drive = top_reg.guard;
  assign guard_time_oe    = top_reg.guard_oe;
  assign irq_callprog_o   = top_reg.pin_o;
  assign irq_callprog_oe  = top_reg.pin_oe;
  assign irq              = |(top_reg.evt & top_reg.mask);

  // ****************************************
  // checks
  // ****************************************
  default clocking tpsv_cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  early_follow_a: assert property (
    (tone.valid != early_steer) && !top_reg.ctrl[CTRL_CALLPROG_POS]
      && !$past(top_reg.ctrl[CTRL_CALLPROG_POS]) |=> early_steer == $past(tone.valid))
    else $error("early steer does not follow the signal condition");

  code_capture_a: assert property (
    top_reg.state == TPSV_IDLE && steer_sync && early_steer
      |=> top_reg.state == TPSV_SETTLE && top_reg.cap_code == $past(enc_code))
    else $error("tone pair not registered on steer crossing");

  guard_high_a: assert property (
    top_reg.dsteer && early_steer && steer_sync |=> guard_time_drive && guard_time_oe)
    else $error("guard output not driven high during valid tone");

  settle_delay_a: assert property (
    $rose(top_reg.state == TPSV_SETTLE) |-> !top_reg.dsteer[*3] ##1 top_reg.dsteer)
    else $error("delayed steer timing after registration wrong");

  latch_update_a: assert property (
    $changed(top_reg.rx_code) |-> $rose(top_reg.dsteer))
    else $error("receive code changed outside delayed steer rise");

  rx_read_a: assert property (
    avs_req.read && !avs_waitrequest && avs_req.address == ADDR_RX_DATA
      |-> avs_readdata[3:0] == $past(top_reg.rx_code))
    else $error("receive data read does not return latched code");

  pause_hold_a: assert property (
    top_reg.dsteer && steer_sync |=> top_reg.dsteer && $stable(top_reg.rx_code))
    else $error("steering state lost while steer input high");

  valid_set_a: assert property (
    $rose(top_reg.dsteer) |-> top_reg.rx_valid && top_reg.evt[EVT_NEW_DATA_POS])
    else $error("data valid not set on registration");

  irq_pin_a: assert property (
    top_reg.ctrl == 2'h1 && top_reg.rx_valid |=> irq_callprog_oe && !irq_callprog_o)
    else $error("interrupt pin not pulled low");

  // ****************************************
  // status, pin and steering checks
  // ****************************************
  status_clear_a: assert property (
    avs_req.read && !avs_waitrequest && avs_req.address == ADDR_STATUS
      && !(top_reg.state == TPSV_SETTLE && top_reg.cnt == SETTLE_LAST)
      |=> !top_reg.rx_valid)
    else $error("data valid bit not cleared by status read");

  set_wins_a: assert property (
    avs_req.read && !avs_waitrequest && avs_req.address == ADDR_STATUS
      && top_reg.state == TPSV_SETTLE && top_reg.cnt == SETTLE_LAST
      |=> top_reg.rx_valid && top_reg.evt[EVT_NEW_DATA_POS])
    else $error("status read cleared a fresh registration");

  status_valid_a: assert property (
    avs_req.read && !avs_waitrequest && avs_req.address == ADDR_STATUS
      |-> avs_readdata[RX_DATA_VALID_POS] == $past(top_reg.rx_valid))
    else $error("status data valid bit wrong");

  status_steer_a: assert property (
    avs_req.read && !avs_waitrequest && avs_req.address == ADDR_STATUS
      |-> avs_readdata[DELAYED_STEER_POS] != $past(top_reg.dsteer))
    else $error("status delayed steer bit not active low");

  tone_end_a: assert property (
    top_reg.dsteer && !steer_sync |=> !top_reg.dsteer && top_reg.evt[EVT_TONE_END_POS])
    else $error("tone end not flagged after absent guard time");

  valid_stays_a: assert property (
    top_reg.state == TPSV_VALID |-> top_reg.dsteer)
    else $error("delayed steer low while tone still valid");

  code_hold_a: assert property (
    $fell(top_reg.dsteer) |-> $stable(top_reg.rx_code))
    else $error("receive code changed at tone end");

  short_burst_a: assert property (
    top_reg.state == TPSV_IDLE && !steer_sync
      |=> top_reg.state == TPSV_IDLE && !top_reg.dsteer)
    else $error("registration without steer input crossing");

  cp_pin_a: assert property (
    top_reg.ctrl[CTRL_CALLPROG_POS]
      |=> irq_callprog_oe && irq_callprog_o == $past(callprog_square_in))
    else $error("call progress output does not follow comparator");

  cp_no_tone_a: assert property (
    top_reg.ctrl[CTRL_CALLPROG_POS] |=> !early_steer)
    else $error("tone pair detected in call progress mode");

  guard_low_a: assert property (
    !early_steer || !steer_sync |=> !guard_time_drive)
    else $error("guard output high without early steer and steer level");

  guard_oe_a: assert property (
    top_reg.dsteer |-> guard_time_oe)
    else $error("guard output not enabled during valid tone");

  early_drop_a: assert property (
    !tone.valid |=> !early_steer)
    else $error("early steer stays high after loss of signal");

  pin_release_a: assert property (
    top_reg.ctrl == 2'h1 && !top_reg.rx_valid |=> !irq_callprog_oe)
    else $error("interrupt pin pulled low with no pending data");

  sync_delay_a: assert property (
    1'b1 |-> steer_sync == $past(steer_level_in, 2))
    else $error("steer input not passed through two flip-flops");

  valid_src_a: assert property (
    $rose(top_reg.rx_valid) |-> $rose(top_reg.dsteer))
    else $error("data valid set without a registration");

  settle_hold_a: assert property (
    top_reg.state == TPSV_SETTLE |-> !top_reg.dsteer && top_reg.cnt <= SETTLE_LAST)
    else $error("delayed steer raised before settling ended");

endmodule : tpsv_top

// ==== rtl/tpsv_pkg.sv ====
package tpsv_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS  = 40;
  localparam int SETTLE_TIME_NS = 120;
  localparam int SETTLE_CYC_INT = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SETTLE_CYC  = 3'((SETTLE_CYC_INT < 1) ? 1 : SETTLE_CYC_INT);
  localparam logic [2:0] SETTLE_LAST = 3'(SETTLE_CYC - 3'h1);

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [4:0] ADDR_RX_DATA = 5'h00;
  localparam logic [4:0] ADDR_STATUS  = 5'h04;
  localparam logic [4:0] ADDR_CTRL    = 5'h08;
  localparam logic [4:0] ADDR_EVENT   = 5'h0C;
  localparam logic [4:0] ADDR_MASK    = 5'h10;

  localparam int RX_DATA_VALID_POS = 2;
  localparam int DELAYED_STEER_POS = 3;
  localparam int CTRL_IRQ_MODE_POS = 0;
  localparam int CTRL_CALLPROG_POS = 1;
  localparam int EVT_NEW_DATA_POS  = 0;
  localparam int EVT_TONE_END_POS  = 1;

  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [3:0] CODE_RST = 4'h0;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    TPSV_IDLE   = 2'b00,
    TPSV_SETTLE = 2'b01,
    TPSV_VALID  = 2'b10
  } tpsv_state_t;

  typedef struct packed {
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } tpsv_avs_req_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] low_idx;
    logic [1:0] high_idx;
  } tpsv_tone_t;

endpackage : tpsv_pkg

// ==== rtl/tpsv_sync.sv ====
`timescale 1ns/1ns
module tpsv_sync
  import tpsv_pkg::*;
(
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic d_in,
  output logic      q_out
);

  typedef struct packed {
    logic s1;
    logic s2;
  } tpsv_sync_st_t;

  tpsv_sync_st_t sync_reg;
  tpsv_sync_st_t sync_next;

  always_comb begin
    sync_next    = sync_reg;
    sync_next.s1 = d_in;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign q_out = sync_reg.s2;

endmodule : tpsv_sync

// ==== rtl/tpsv_code_enc.sv ====
`timescale 1ns/1ns
module tpsv_code_enc
  import tpsv_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire tpsv_tone_t tone,
  output logic [3:0]      code_q
);

  // row index 0..3 is 697..941 Hz, column index 0..3 is 1209..1633 Hz
  function automatic logic [3:0] tpsv_digit_code(input logic [1:0] lo, input logic [1:0] hi);
    logic [3:0] c;
    c = 4'h0;
    case ({lo, hi})
      4'h0: c = 4'h1;
      4'h1: c = 4'h2;
      4'h2: c = 4'h3;
      4'h3: c = 4'hD;
      4'h4: c = 4'h4;
      4'h5: c = 4'h5;
      4'h6: c = 4'h6;
      4'h7: c = 4'hE;
      4'h8: c = 4'h7;
      4'h9: c = 4'h8;
      4'hA: c = 4'h9;
      4'hB: c = 4'hF;
      4'hC: c = 4'hB;
      4'hD: c = 4'hA;
      4'hE: c = 4'hC;
      default: c = 4'h0;
    endcase
    return c;
  endfunction : tpsv_digit_code

  logic [3:0] code_reg;
  logic [3:0] code_next;

  always_comb begin
    code_next = tpsv_digit_code(tone.low_idx, tone.high_idx);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      code_reg <= CODE_RST;
    end else begin
      code_reg <= code_next;
    end
  end

  assign code_q = code_reg;

endmodule : tpsv_code_enc

// ==== tb/tpsv_rc_model.sv ====
`timescale 1ns/1ns
// ****************************************
// external rc steering network
// ****************************************
module tpsv_rc_model #(
  parameter int GTP_CYC = 12,
  parameter int GTA_CYC = 12
) (
  input  wire logic mclk,
  input  wire logic early_steer,
  input  wire logic guard_time_drive,
  input  wire logic guard_time_oe,
  output logic      steer_level_in
);
  int pc = 0;
  int ac = 0;
  initial steer_level_in = 1'h0;
  // capacitor charges while early steer holds, guard drive keeps it high
  always @(posedge mclk) begin
    pc <= early_steer ? pc + 1 : 0;
    ac <= early_steer ? 0 : ac + 1;
    if (!steer_level_in && pc >= GTP_CYC) steer_level_in <= 1'h1;
    if (steer_level_in && !(guard_time_drive && guard_time_oe) && ac >= GTA_CYC)
      steer_level_in <= 1'h0;
  end
endmodule : tpsv_rc_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  import tpsv_pkg::*;
  logic          mclk;
  logic          arst_n;
  tpsv_avs_req_t avs_req;
  logic [31:0]   avs_readdata;
  logic          avs_waitrequest;
  tpsv_tone_t    tone;
  logic          callprog_square_in;
  logic          early_steer;
  logic          steer_level_in;
  logic          guard_time_drive;
  logic          guard_time_oe;
  logic          irq_callprog_o;
  logic          irq_callprog_oe;
  logic          irq;
  int            fail_count = 0;
  int            comparisons = 0;
  logic [3:0]    code_tab [16] = '{4'h1, 4'h2, 4'h3, 4'hD, 4'h4, 4'h5, 4'h6, 4'hE,
                                   4'h7, 4'h8, 4'h9, 4'hF, 4'hB, 4'hA, 4'hC, 4'h0};

  tpsv_top dut_u (.mclk(mclk), .arst_n(arst_n), .avs_req(avs_req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .tone(tone),
    .callprog_square_in(callprog_square_in), .early_steer(early_steer),
    .steer_level_in(steer_level_in), .guard_time_drive(guard_time_drive),
    .guard_time_oe(guard_time_oe), .irq_callprog_o(irq_callprog_o),
    .irq_callprog_oe(irq_callprog_oe), .irq(irq));

  tpsv_rc_model rc_u (.mclk(mclk), .early_steer(early_steer),
    .guard_time_drive(guard_time_drive), .guard_time_oe(guard_time_oe),
    .steer_level_in(steer_level_in));

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge mclk);
    avs_req <= '{a, !wr, wr, wd};
    do @(posedge mclk); while (avs_waitrequest !== 1'h0);
    rd = avs_readdata;
    avs_req <= '0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'h1, a, d, r);
  endtask : wr

  task automatic rdchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    bus(1'h0, a, 32'h0, r);
    check(r & m, e);
  endtask : rdchk

  task automatic tone_set(input logic v, input int i);
    @(posedge mclk);
    tone <= {v, i[3:2], i[1:0]};
  endtask : tone_set

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'h1 && n < 80) begin
      @(negedge mclk);
      n++;
    end
  endtask : wait_irq

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset();
    rdchk(ADDR_CTRL, 32'hFFFFFFFF, 32'h0);
    rdchk(ADDR_MASK, 32'hFFFFFFFF, 32'h0);
    rdchk(ADDR_RX_DATA, 32'hFFFFFFFF, 32'h0);
    rdchk(ADDR_STATUS, 32'hFFFFFFFF, 32'h8);
    wr(5'h14, 32'hFFFFFFFF);
    rdchk(5'h14, 32'hFFFFFFFF, 32'h0);
  endtask : test_reset

  task automatic send_digit(input int i);
    tone_set(1'h1, i);
    wait_irq();
    check(irq, 1'h1);
    check(early_steer, 1'h1);
    check(guard_time_drive, 1'h1);
    check(guard_time_oe, 1'h1);
    @(negedge mclk);
    check(irq_callprog_oe, 1'h1);
    check(irq_callprog_o, 1'h0);
    rdchk(ADDR_RX_DATA, 32'hFFFFFFFF, {28'h0, code_tab[i]});
    rdchk(ADDR_STATUS, 32'hC, 32'h4);
    rdchk(ADDR_STATUS, 32'h4, 32'h0);
    repeat (2) @(negedge mclk);
    check(irq_callprog_oe, 1'h0);
    tone_set(1'h0, i);
    repeat (2) @(negedge mclk);
    check(early_steer, 1'h0);
    @(negedge mclk);
    check(guard_time_drive, 1'h0);
    repeat (30) @(negedge mclk);
    rdchk(ADDR_STATUS, 32'h8, 32'h8);
    rdchk(ADDR_EVENT, 32'h3, 32'h3);
    wr(ADDR_EVENT, 32'h3);
    @(negedge mclk);
    check(irq, 1'h0);
    rdchk(ADDR_RX_DATA, 32'hF, {28'h0, code_tab[i]});
  endtask : send_digit

  task automatic test_digits();
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_MASK, 32'h3);
    for (int i = 15; i >= 0; i--) send_digit(i);
  endtask : test_digits

  task automatic test_short();
    tone_set(1'h1, 5);
    repeat (5) @(posedge mclk);
    tone_set(1'h0, 5);
    repeat (30) @(negedge mclk);
    rdchk(ADDR_RX_DATA, 32'hF, {28'h0, code_tab[0]});
    rdchk(ADDR_EVENT, 32'h3, 32'h0);
  endtask : test_short

  task automatic test_dropout();
    tone_set(1'h1, 6);
    wait_irq();
    wr(ADDR_EVENT, 32'h3);
    tone_set(1'h0, 6);
    repeat (4) @(posedge mclk);
    tone_set(1'h1, 6);
    repeat (20) @(negedge mclk);
    rdchk(ADDR_EVENT, 32'h3, 32'h0);
    rdchk(ADDR_STATUS, 32'h8, 32'h0);
    rdchk(ADDR_RX_DATA, 32'hF, {28'h0, code_tab[6]});
    tone_set(1'h0, 6);
    repeat (30) @(negedge mclk);
    wr(ADDR_EVENT, 32'h3);
  endtask : test_dropout

  task automatic test_callprog();
    wr(ADDR_CTRL, 32'h2);
    tone_set(1'h1, 0);
    repeat (3) @(negedge mclk);
    check(early_steer, 1'h0);
    @(posedge mclk);
    callprog_square_in <= 1'h1;
    repeat (2) @(negedge mclk);
    check({irq_callprog_oe, irq_callprog_o}, 2'h3);
    @(posedge mclk);
    callprog_square_in <= 1'h0;
    repeat (2) @(negedge mclk);
    check({irq_callprog_oe, irq_callprog_o}, 2'h2);
    repeat (30) @(negedge mclk);
    rdchk(ADDR_EVENT, 32'h3, 32'h0);
    tone_set(1'h0, 0);
  endtask : test_callprog

  task automatic print_verdict();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    print_verdict();
  end

  initial begin
    arst_n = 1'h0;
    avs_req = '0;
    tone = '0;
    callprog_square_in = 1'h0;
    repeat (20) @(posedge mclk);
    arst_n <= 1'h1;
    test_reset();
    test_digits();
    test_short();
    test_dropout();
    test_callprog();
    print_verdict();
  end
endmodule : tb_top
